// ### rtl/tsil_consts.svh
// Constants of the three-source interrupt logic
`ifndef TSIL_CONSTS_SVH
`define TSIL_CONSTS_SVH
`define TSIL_PC_W        12
`define TSIL_VECTOR      12'h008
`define TSIL_OFS_EDGE    8'hBF
`define TSIL_OFS_REQ     8'hC8
`define TSIL_OFS_EN      8'hC9
`define TSIL_OFS_STK     8'hDF
`define TSIL_BIT_PIN     0
`define TSIL_BIT_TA      4
`define TSIL_BIT_TB      5
`define TSIL_BIT_GLOBAL  7
`define TSIL_EDGE_LO     3
`define TSIL_EDGE_HI     4
`define TSIL_EDGE_RST    2'h2
`define TSIL_STK_RST     2'h3
`define TSIL_CODE_RES    2'h0
`define TSIL_CODE_RISE   2'h1
`define TSIL_CODE_FALL   2'h2
`define TSIL_CODE_BOTH   2'h3
`define TSIL_FLAG_KEEP   8'h3F
`define TSIL_ZERO8       8'h00
`endif

// ### rtl/tsil_pkg.sv
// Types of the three-source interrupt logic
`default_nettype none
`include "tsil_consts.svh"
package tsil_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tsil_bus_type;

    typedef struct packed {
        logic       pin_s1;
        logic       pin_s2;
        logic       pin_s3;
        logic       pin_level;
        logic [1:0] pin_edge_code;
        logic       pin_request_flag;
        logic       timer_a_request_flag;
        logic       timer_b_request_flag;
        logic       pin_irq_enable;
        logic       timer_a_irq_enable;
        logic       timer_b_irq_enable;
        logic       timer_b_armed;
        logic       global_irq_enable;
        logic [1:0] stack_level;
        logic       wake_latch;
        logic       wake_req;
        logic [7:0] save_accum;
        logic [7:0] save_flag;
        logic [7:0] accumulator_out;
        logic [7:0] program_flag_out;
        logic       restore_valid;
        logic       vector_load;
        logic [`TSIL_PC_W-1:0] vector_pc;
        logic [7:0] rdata;
    } tsil_state_type;
endpackage
`default_nettype wire

// ### rtl/tsil_core.sv
// Three-source interrupt logic: flags, enables, vector entry and save buffer
// ==========================================================================
// Overview of operation
// RULE_01: Accepted interrupt loads program counter with 8
// RULE_02: Save copies accumulator and flags; restore reloads (the code saves only flag bits 5:0, so bits 7:6 restore as zero)
// RULE_03: Save buffer has one level; resave overwrites
// RULE_04: Configured pin edge sets pin flag always
// RULE_05: Enabled pin edge branches to the vector
// RULE_06: Matching wake edge latched, serviced first after wake
// RULE_07: Edge code: reserved, rising, falling, both
// RULE_08: Timer A overflow always sets its flag
// RULE_09: Timer A branches only when enabled
// RULE_10: Timer B overflow sets flag, branches if enabled
// RULE_11: Timer B flag set while disabled never branches
// RULE_12: Software must not reload timer A in clock mode
// RULE_13: Software clears flags with single-bit operations
// RULE_14: Service routine polls sources in its own order
// RULE_15: Entry pushes stack, clears global enable; return sets
// RULE_16: Flags at bits 0, 4, 5; sticky until cleared
// RULE_17: Enables at bits 0, 4, 5; reset zero
// RULE_18: Pin synchronised; reserved code makes no requests
// RULE_19: Hardware set wins over software clear
//
// The implementer's own choice: the plain strobed port.
`default_nettype none
`include "tsil_consts.svh"
module tsil_core
    import tsil_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  external_pin_irq,
    input  wire logic                  timer_a_overflow,
    input  wire logic                  timer_b_overflow,
    input  wire logic                  power_down,
    input  wire logic                  cpu_boundary,
    input  wire logic                  return_from_irq,
    input  wire logic                  save_exec,
    input  wire logic                  restore_exec,
    input  wire logic [7:0]            accumulator,
    input  wire logic [7:0]            program_flag_reg,
    output logic                       irq_pending,
    output logic                       vector_load,
    output logic      [`TSIL_PC_W-1:0] vector_pc,
    output logic                       wake_req,
    output logic                       restore_valid,
    output logic      [7:0]            accumulator_out,
    output logic      [7:0]            program_flag_out
);
    // ======================================================================
    // Decoding
    // ======================================================================
    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic       rise,
                                      input logic       fall);
        logic hit;
        hit = 1'b0;
        case (code)
            `TSIL_CODE_RISE: hit = rise;
            `TSIL_CODE_FALL: hit = fall;
            `TSIL_CODE_BOTH: hit = rise | fall;
            default:         hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic hit_addr(input tsil_bus_type b, input logic [7:0] ofs);
        return b.addr == ofs;
    endfunction

    tsil_state_type state;
    tsil_state_type next_state;
    tsil_bus_type   bus;
    logic           pin_change;
    logic           pin_rise;
    logic           pin_fall;
    logic           pin_event;
    logic [2:0]     pend_vec;
    logic           accept;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ======================================================================
    // Pin edge detection and request generation
    // ======================================================================
    // A change counts once the second and third stages agree
    assign pin_change = (state.pin_s2 == state.pin_s3) &&
                        (state.pin_s3 != state.pin_level);            // [RULE_18]
    assign pin_rise   = pin_change && state.pin_s3;
    assign pin_fall   = pin_change && !state.pin_s3;
    assign pin_event  = edge_hit(state.pin_edge_code, pin_rise, pin_fall); // [RULE_07]

    assign pend_vec[0] = state.pin_request_flag && state.pin_irq_enable;   // [RULE_05]
    assign pend_vec[1] = state.timer_a_request_flag &&
                         state.timer_a_irq_enable;                     // [RULE_09]
    assign pend_vec[2] = state.timer_b_request_flag && state.timer_b_armed &&
                         state.timer_b_irq_enable;                     // [RULE_10] [RULE_11]
    assign irq_pending = state.global_irq_enable &&
                         ((|pend_vec) || state.wake_latch);            // [RULE_06]
    assign accept      = irq_pending && cpu_boundary;

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        next_state = state;
        next_state.pin_s1 = external_pin_irq;
        next_state.pin_s2 = state.pin_s1;
        next_state.pin_s3 = state.pin_s2;
        if (pin_change) begin
            next_state.pin_level = state.pin_s3;
        end
        next_state.vector_load   = 1'b0;
        next_state.restore_valid = 1'b0;
        next_state.wake_req      = 1'b0;
        next_state.rdata         = `TSIL_ZERO8;

        // Software writes
        if (bus.wr) begin
            if (hit_addr(bus, `TSIL_OFS_EDGE)) begin
                next_state.pin_edge_code = bus.wdata[`TSIL_EDGE_HI:`TSIL_EDGE_LO];
            end
            if (hit_addr(bus, `TSIL_OFS_REQ)) begin
                next_state.pin_request_flag     = bus.wdata[`TSIL_BIT_PIN]; // [RULE_16]
                next_state.timer_a_request_flag = bus.wdata[`TSIL_BIT_TA];
                next_state.timer_b_request_flag = bus.wdata[`TSIL_BIT_TB];
                if (!bus.wdata[`TSIL_BIT_TB]) begin
                    next_state.timer_b_armed = 1'b0;
                end
            end
            if (hit_addr(bus, `TSIL_OFS_EN)) begin
                next_state.pin_irq_enable     = bus.wdata[`TSIL_BIT_PIN]; // [RULE_17]
                next_state.timer_a_irq_enable = bus.wdata[`TSIL_BIT_TA];
                next_state.timer_b_irq_enable = bus.wdata[`TSIL_BIT_TB];
            end
            if (hit_addr(bus, `TSIL_OFS_STK)) begin
                next_state.global_irq_enable = bus.wdata[`TSIL_BIT_GLOBAL];
                next_state.stack_level       = bus.wdata[1:0];
            end
        end

        // Hardware sets come after the writes so that they win
        if (pin_event) begin
            next_state.pin_request_flag = 1'b1;                        // [RULE_04] [RULE_19]
            if (power_down) begin
                next_state.wake_latch = 1'b1;                          // [RULE_06]
                next_state.wake_req   = 1'b1;
            end
        end
        if (timer_a_overflow) begin
            next_state.timer_a_request_flag = 1'b1;                    // [RULE_08] [RULE_19]
        end
        if (timer_b_overflow) begin
            next_state.timer_b_request_flag = 1'b1;                    // [RULE_10] [RULE_19]
            next_state.timer_b_armed = state.timer_b_irq_enable;       // [RULE_11]
        end

        // Entry and return
        if (accept) begin
            next_state.vector_load       = 1'b1;
            next_state.vector_pc         = `TSIL_VECTOR;               // [RULE_01]
            next_state.global_irq_enable = 1'b0;                       // [RULE_15]
            next_state.stack_level       = state.stack_level - 2'h1;
            next_state.wake_latch        = 1'b0;
        end else if (return_from_irq) begin
            next_state.global_irq_enable = 1'b1;                       // [RULE_15]
            next_state.stack_level       = state.stack_level + 2'h1;
        end

        // One shared save level
        if (save_exec) begin
            next_state.save_accum = accumulator;                       // [RULE_02] [RULE_03]
            next_state.save_flag = program_flag_reg & `TSIL_FLAG_KEEP;
        end
        if (restore_exec) begin
            next_state.accumulator_out  = state.save_accum;            // [RULE_02]
            next_state.program_flag_out = state.save_flag;
            next_state.restore_valid    = 1'b1;
        end

        // Register reads
        if (bus.rd) begin
            case (bus.addr)
                `TSIL_OFS_EDGE: begin
                    next_state.rdata[`TSIL_EDGE_HI:`TSIL_EDGE_LO] = state.pin_edge_code;
                end
                `TSIL_OFS_REQ: begin
                    next_state.rdata[`TSIL_BIT_PIN] = state.pin_request_flag;
                    next_state.rdata[`TSIL_BIT_TA]  = state.timer_a_request_flag;
                    next_state.rdata[`TSIL_BIT_TB]  = state.timer_b_request_flag;
                end
                `TSIL_OFS_EN: begin
                    next_state.rdata[`TSIL_BIT_PIN] = state.pin_irq_enable;
                    next_state.rdata[`TSIL_BIT_TA]  = state.timer_a_irq_enable;
                    next_state.rdata[`TSIL_BIT_TB]  = state.timer_b_irq_enable;
                end
                `TSIL_OFS_STK: begin
                    next_state.rdata[`TSIL_BIT_GLOBAL] = state.global_irq_enable;
                    next_state.rdata[1:0]           = state.stack_level;
                end
                default: begin
                    next_state.rdata = `TSIL_ZERO8;
                end
            endcase
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state               <= '0;
            state.pin_edge_code <= `TSIL_EDGE_RST;
            state.stack_level   <= `TSIL_STK_RST;
            state.vector_pc     <= `TSIL_VECTOR;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata        = state.rdata;
    assign vector_load      = state.vector_load;
    assign vector_pc        = state.vector_pc;
    assign wake_req         = state.wake_req;
    assign restore_valid    = state.restore_valid;
    assign accumulator_out  = state.accumulator_out;
    assign program_flag_out = state.program_flag_out;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_vector;
        vector_load |-> vector_pc == `TSIL_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("Vector not 8"); // [RULE_01]

    property p_entry;
        accept |=> vector_load && !state.global_irq_enable;
    endproperty
    a_entry: assert property (p_entry) else $error("Entry failed"); // [RULE_15]

    property p_return;
        return_from_irq && !accept |=> state.global_irq_enable;
    endproperty
    a_return: assert property (p_return) else $error("Return no enable"); // [RULE_15]

    property p_pin_flag;
        pin_event |=> state.pin_request_flag;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("Pin flag lost"); // [RULE_04]

    property p_reserved;
        state.pin_edge_code == `TSIL_CODE_RES |-> !pin_event;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved code hit"); // [RULE_18]

    property p_ta_flag;
        timer_a_overflow |=> state.timer_a_request_flag;
    endproperty
    a_ta_flag: assert property (p_ta_flag) else $error("Timer A flag lost"); // [RULE_08]

    property p_tb_unarmed;
        state.timer_b_request_flag && !state.timer_b_armed |-> !pend_vec[2];
    endproperty
    a_tb_unarmed: assert property (p_tb_unarmed) else $error("Stale B branch"); // [RULE_11]

    property p_restore;
        restore_exec && !save_exec |=>
            restore_valid && accumulator_out == $past(state.save_accum);
    endproperty
    a_restore: assert property (p_restore) else $error("Restore wrong"); // [RULE_02]

    property p_one_level;
        save_exec |=> state.save_accum == $past(accumulator);
    endproperty
    a_one_level: assert property (p_one_level) else $error("Save not overwritten"); // [RULE_03]

    property p_tb_flag;
        timer_b_overflow |=> state.timer_b_request_flag;
    endproperty
    a_tb_flag: assert property (p_tb_flag) else $error("Timer B flag lost"); // [RULE_10]

    property p_wake;
        pin_event && power_down && !accept |=> wake_req && state.wake_latch;
    endproperty
    a_wake: assert property (p_wake) else $error("Wake edge not latched"); // [RULE_06]

    property p_sticky;
        state.pin_request_flag && !(reg_wr && reg_addr == `TSIL_OFS_REQ) |=>
            state.pin_request_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("Pin flag dropped"); // [RULE_16]

    c_accept: cover property (accept);
    c_wake:   cover property (wake_req ##[1:20] vector_load);
    c_save:   cover property (save_exec ##[1:20] restore_exec);
    c_stale:  cover property (state.timer_b_request_flag && !state.timer_b_armed &&
                              state.timer_b_irq_enable);
endmodule
`default_nettype wire

// ### verif/tsil_far_model.sv
// Far-side model: timer overflows, CPU sequencer strobes and values, the interrupt pin
`default_nettype none
module tsil_far_model (
    input  wire logic       core_clk,
    output logic      [5:0] evt,
    output logic            pin,
    output logic            power_down,
    output logic      [7:0] accum_val,
    output logic      [7:0] flag_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] evt_q;
    logic       pin_q;
    logic       sleep_q;
    logic [7:0] accum_q;
    logic [7:0] flag_q;
    initial begin
        evt_q   = 6'h00;
        pin_q   = 1'b1;
        sleep_q = 1'b0;
        accum_q = 8'h00;
        flag_q  = 8'h00;
    end
    assign evt        = evt_q;
    assign pin        = pin_q;
    assign power_down = sleep_q;
    assign accum_val  = accum_q;
    assign flag_val   = flag_q;
    // One-cycle strobe: 0 timer A, 1 timer B, 2 boundary, 3 return, 4 save, 5 restore
    // Timer counters are never reloaded from here while serviced
    task automatic pulse(input int i);
        @(posedge core_clk);
        evt_q[i] <= 1'b1;
        @(posedge core_clk);
        evt_q[i] <= 1'b0;
    endtask
    // Pin level changes only just after a clock edge
    task automatic pin_to(input logic v);
        @(posedge core_clk);
        pin_q <= v;
    endtask
    // Power-down level of the CPU
    task automatic set_sleep(input logic v);
        @(posedge core_clk);
        sleep_q <= v;
    endtask
    // Accumulator and flag values that a save instruction picks up
    task automatic set_cpu(input logic [7:0] a, input logic [7:0] f);
        @(posedge core_clk);
        accum_q <= a;
        flag_q  <= f;
    endtask
endmodule
`default_nettype wire

// ### verif/tsil_core_tb.sv
// Self-checking bench for the three-source interrupt logic
`default_nettype none
`include "tsil_consts.svh"
module tsil_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata, accum_ret, flags_ret, accum_val, flag_val;
    logic [5:0]  evt;
    logic        pin, power_down, irq_pending, vector_load, wake_req, restore_valid;
    logic [11:0] vector_pc;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          seen;

    tsil_far_model far (.core_clk(core_clk), .evt(evt), .pin(pin), .power_down(power_down),
        .accum_val(accum_val), .flag_val(flag_val));
    tsil_core dut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_pin_irq(pin),
        .timer_a_overflow(evt[0]), .timer_b_overflow(evt[1]), .power_down(power_down),
        .cpu_boundary(evt[2]), .return_from_irq(evt[3]), .save_exec(evt[4]),
        .restore_exec(evt[5]), .accumulator(accum_val), .program_flag_reg(flag_val),
        .irq_pending(irq_pending), .vector_load(vector_load), .vector_pc(vector_pc),
        .wake_req(wake_req), .restore_valid(restore_valid), .accumulator_out(accum_ret),
        .program_flag_out(flags_ret));

    always #2.5 core_clk = ~core_clk;

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk({11'h000, got}, {11'h000, exp}, what);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk({4'h0, reg_rdata}, {4'h0, e}, what);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Boundary strobe, then look at the vector load one cycle on
    task automatic enter(input logic exp, input string what);
        far.pulse(2);
        #1;
        chk1(vector_load, exp, what);
        if (exp)
            chk(vector_pc, `TSIL_VECTOR, "vector address");
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`TSIL_OFS_EDGE, 8'h10, "edge reset");
        rd(`TSIL_OFS_REQ, 8'h00, "flag reset");
        rd(`TSIL_OFS_EN, 8'h00, "enable reset");
        rd(`TSIL_OFS_STK, 8'h03, "stack reset");
        rd(8'h55, 8'h00, "unmapped read");
        $display("test reset done");

        wr(`TSIL_OFS_STK, 8'h83);
        far.pulse(0);
        wait_n(2);
        rd(`TSIL_OFS_REQ, 8'h10, "timer a flag");
        enter(1'b0, "timer a masked");
        wr(`TSIL_OFS_EN, 8'h10);
        wait_n(1);
        chk1(irq_pending, 1'b1, "timer a pending");
        enter(1'b1, "timer a entry");
        rd(`TSIL_OFS_STK, 8'h02, "entry stack");
        far.pulse(3);
        rd(`TSIL_OFS_STK, 8'h83, "return stack");
        wr(`TSIL_OFS_REQ, 8'h00);
        wr(`TSIL_OFS_EN, 8'h00);
        fork
            wr(`TSIL_OFS_REQ, 8'h00);
            far.pulse(0);
        join
        rd(`TSIL_OFS_REQ, 8'h10, "set beats clear");
        wr(`TSIL_OFS_REQ, 8'h00);
        $display("test timer a done");

        far.pulse(1);
        wait_n(2);
        rd(`TSIL_OFS_REQ, 8'h20, "timer b flag");
        wr(`TSIL_OFS_EN, 8'h20);
        wait_n(1);
        chk1(irq_pending, 1'b0, "stale timer b");
        enter(1'b0, "stale timer b entry");
        wr(`TSIL_OFS_REQ, 8'h00);
        far.pulse(1);
        wait_n(2);
        chk1(irq_pending, 1'b1, "timer b pending");
        enter(1'b1, "timer b entry");
        far.pulse(3);
        wr(`TSIL_OFS_REQ, 8'h00);
        wr(`TSIL_OFS_EN, 8'h00);
        $display("test timer b done");

        for (int c = 0; c < 4; c++) begin
            wr(`TSIL_OFS_EDGE, 8'(c << 3));
            rd(`TSIL_OFS_EDGE, 8'(c << 3), "edge code");
            far.pin_to(1'b0);
            wait_n(6);
            rd(`TSIL_OFS_REQ, {7'h00, c[1]}, "falling edge");
            wr(`TSIL_OFS_REQ, 8'h00);
            far.pin_to(1'b1);
            wait_n(6);
            rd(`TSIL_OFS_REQ, {7'h00, c[0]}, "rising edge");
            wr(`TSIL_OFS_REQ, 8'h00);
        end
        wr(`TSIL_OFS_EN, 8'h01);
        far.pin_to(1'b0);
        wait_n(6);
        chk1(irq_pending, 1'b1, "pin pending");
        enter(1'b1, "pin entry");
        far.pulse(3);
        wr(`TSIL_OFS_REQ, 8'h00);
        wr(`TSIL_OFS_EN, 8'h00);
        $display("test pin done");

        far.set_sleep(1'b1);
        far.pin_to(1'b1);
        seen = 0;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            if (wake_req === 1'b1)
                seen++;
        end
        chk(12'(seen), 12'h001, "wake pulse count");
        far.set_sleep(1'b0);
        wait_n(1);
        chk1(irq_pending, 1'b1, "wake latch pending");
        enter(1'b1, "wake entry");
        far.pulse(3);
        wr(`TSIL_OFS_REQ, 8'h00);
        wait_n(1);
        chk1(irq_pending, 1'b0, "wake latch cleared");
        $display("test wake done");

        far.set_cpu(8'hA5, 8'hFF);
        far.pulse(4);
        far.set_cpu(8'h5A, 8'hC1);
        far.pulse(4);
        far.pulse(5);
        #1;
        chk1(restore_valid, 1'b1, "restore strobe");
        chk({4'h0, accum_ret}, 12'h05A, "restored accumulator");
        chk({4'h0, flags_ret}, 12'h001, "restored flags");
        $display("test save done");
        conclude();
    end
endmodule
`default_nettype wire
